// ===== rtl/hsc_consts.svh
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH
// Register byte offsets, one aligned word each
`define HSC_CH0_ELAPSED_OFS  12'h000
`define HSC_CH0_TARGET_OFS   12'h004
`define HSC_CH1_ELAPSED_OFS  12'h008
`define HSC_CH1_TARGET_OFS   12'h00c
`define HSC_CH2_ELAPSED_OFS  12'h010
`define HSC_CH2_TARGET_OFS   12'h014
`define HSC_CH3_ELAPSED_OFS  12'h018
`define HSC_CH3_TARGET_OFS   12'h01c
`define HSC_CTRL_OFS         12'h020
`define HSC_OUTSEL_OFS       12'h024
`define HSC_FLAG_OFS         12'h028
`define HSC_IRQ_STAT_OFS     12'h02c
`define HSC_IRQ_MASK_OFS     12'h030
`define HSC_OUT_STATE_OFS    12'h034
// Control word fields
`define HSC_CTRL_EN_POS      0
`define HSC_CTRL_DOWN_POS    4
`define HSC_CTRL_TWO_PH_POS  8
`define HSC_CTRL_DIR_MD_POS  9
`define HSC_CTRL_CLR0_POS    10
`define HSC_CTRL_CLR2_POS    11
`define HSC_CTRL_MATCH_POS   12
`define HSC_CTRL_MVAL_POS    16
`define HSC_CTRL_RESET       32'h0000_0000
`define HSC_OUTSEL_RESET     32'h0000_0000
`define HSC_COUNT_RESET      32'h0000_0000
`define HSC_TARGET_RESET     32'h0000_0000
`endif

// ===== rtl/hsc_pkg.sv
package hsc_pkg;
   typedef logic [31:0] hsc_count_t;
   typedef enum logic [2:0] {
      HSC_IDLE  = 3'b001,
      HSC_RUN   = 3'b010,
      HSC_MATCH = 3'b100
   } hsc_state_e;
endpackage : hsc_pkg

// ===== rtl/hsc_edge.sv
`timescale 1ns/10ps
// Edge detector on a level already synchronous to the clock
module hsc_edge
   import hsc_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic level_i,
   output logic      rise_o,
   output logic      fall_o
);
   typedef struct packed {
      logic prev;
   } hsc_edge_s;
   hsc_edge_s st_reg;
   hsc_edge_s st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.prev = level_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise_o = level_i & ~st_reg.prev;
   assign fall_o = ~level_i & st_reg.prev;
endmodule : hsc_edge

// ===== rtl/hsc_top.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "hsc_consts.svh"
// Notes on behaviour
// [RULE1] Four independent counter channels, numbered zero-three
// [RULE2] Channel use depends on selected function
// [RULE3] Count is signed 32-bit two's complement
// [RULE4] Increment past maximum wraps to minimum
// [RULE5] Decrement below minimum wraps to maximum
// [RULE6] Target match switches selected output on/off
// [RULE7] Program keeps interpolation values within 24 bits
// [RULE8] Single-phase inputs a,b,c,d; shared clear inputs
// [RULE9] Two-phase: channels zero, two only; quadrature/direction
// [RULE10] Flag, elapsed word, target word per channel
// [RULE11] Single-phase rate 50/30/20 kHz by channel count
// [RULE12] Each clear input serves one of two channels
// [RULE13] Match output selectable among eight contacts
// [RULE14] Clear edge zeroes count next cycle
// [RULE15] Flag set while channel busy
module hsc_top
   import hsc_pkg::*;
#(
   parameter int NUM_CH  = 4,
   parameter int NUM_OUT = 8
)(
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        COUNT_IN_A_I,
   input  wire logic        COUNT_IN_B_I,
   input  wire logic        CLEAR_IN_LOW_I,
   input  wire logic        COUNT_IN_C_I,
   input  wire logic        COUNT_IN_D_I,
   input  wire logic        CLEAR_IN_HIGH_I,
   output logic      [7:0]  OUT_CONTACT_O,
   output logic      [3:0]  CHAN_FLAG_O,
   output logic             IRQ_O
);
   // The pin map and the contact index width are fixed by the hardware
   if (NUM_CH != 4) begin : g_bad_ch
      $error("hsc_top serves four channels only");
   end
   if (NUM_OUT != 8) begin : g_bad_out
      $error("hsc_top drives eight contacts only");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register map, one aligned word each
   //   0x00 + 8*c   elapsed count of channel c
   //   0x04 + 8*c   target count of channel c
   //   0x20         control word
   //   0x24         match contact per channel, three bits at 4*c
   //   0x28         busy flags, read only
   //   0x2c         event status, write one to clear
   //   0x30         event mask
   //   0x34         contact state, written directly
   //   other        error response, no effect
   // Control word
   //   [3:0]        count enable per channel
   //   [7:4]        count down per channel, single-phase only
   //   [8]          channel 0 two-phase
   //   [9]          channel 2 two-phase
   //   [10]         low clear to channel 1; pulse plus direction in two-phase
   //   [11]         high clear to channel 3
   //   [15:12]      one-shot match enable per channel
   //   [19:16]      contact level driven on match per channel
   // Bit 10 does double duty, so a two-phase channel keeps its clear input
   // whatever that bit says; its partner channel does not count then anyway

   ////////////////////////////////////////////////////////////////////////////
   // State
   // Everything the block remembers apart from the pin edge history, registered as one word
   typedef struct packed {
      hsc_count_t [3:0] count;
      hsc_count_t [3:0] target;
      logic [31:0]      ctrl;
      logic [31:0]      outsel;
      logic [3:0]       irq_stat;
      logic [3:0]       irq_mask;
      logic [7:0]       outs;
      logic [3:0]       busy;
      logic [31:0]      rdata;
      hsc_state_e [3:0] st;
   } hsc_top_s;
   hsc_top_s st_reg;
   hsc_top_s st_next;

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on field inputs
   logic [5:0] pin_lvl;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;
   assign pin_lvl = {CLEAR_IN_HIGH_I,
                     COUNT_IN_D_I,
                     COUNT_IN_C_I,
                     CLEAR_IN_LOW_I,
                     COUNT_IN_B_I,
                     COUNT_IN_A_I};

   // Every pin is sampled each clock, far above the field pulse rates
   for (genvar g = 0; g < 6; g++) begin : g_edge // [RULE11]
      hsc_edge u_edge (
         .sys_clk_i (SYS_CLK_I),
         .rst_i     (RST_I),
         .level_i   (pin_lvl[g]),
         .rise_o    (pin_rise[g]),
         .fall_o    (pin_fall[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   // Wrapping step: plain 32-bit modulo add gives ring behaviour both ways
   function automatic hsc_count_t step(input hsc_count_t v, input logic dn);
      step = dn ? 32'(v - 32'h0000_0001) : 32'(v + 32'h0000_0001); // [RULE3] [RULE4] [RULE5]
   endfunction : step

   // Full-address compare, so unaligned addresses never hit
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
      reg_hit = (a == ofs);
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic       wr;
   logic       rd;
   logic       two_ph0;
   logic       two_ph2;
   logic       dir_md;
   logic [3:0] en;
   logic [3:0] dn;
   logic [3:0] inc;
   logic [3:0] dec;
   logic [3:0] clr;
   logic [3:0] hit;
   logic       mapped;

   // Reads are decoded in setup, writes in access
   assign wr      = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd      = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   assign two_ph0 = st_reg.ctrl[`HSC_CTRL_TWO_PH_POS];
   assign two_ph2 = st_reg.ctrl[`HSC_CTRL_TWO_PH_POS + 1];
   assign dir_md  = st_reg.ctrl[`HSC_CTRL_DIR_MD_POS + 1];
   assign en      = st_reg.ctrl[`HSC_CTRL_EN_POS +: 4];
   assign dn      = st_reg.ctrl[`HSC_CTRL_DOWN_POS +: 4];

   assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `HSC_OUT_STATE_OFS);

   // Count events per channel
   always_comb begin
      inc = 4'h0;
      dec = 4'h0;
      // Single-phase: one pulse input each [RULE8]
      inc[0] = pin_rise[0] & ~dn[0];
      dec[0] = pin_rise[0] & dn[0];
      inc[1] = pin_rise[1] & ~dn[1] & ~two_ph0;
      dec[1] = pin_rise[1] & dn[1] & ~two_ph0;
      inc[2] = pin_rise[3] & ~dn[2];
      dec[2] = pin_rise[3] & dn[2];
      inc[3] = pin_rise[4] & ~dn[3] & ~two_ph2;
      dec[3] = pin_rise[4] & dn[3] & ~two_ph2;
      // Two-phase borrows the partner channel's pins [RULE9] [RULE2]
      // Quadrature counts every edge of either phase, its sense set by the other
      // phase's level: four counts per cycle, and a bouncing edge undoes itself
      if (two_ph0) begin
         if (dir_md) begin
            inc[0] = pin_rise[0] & ~COUNT_IN_B_I;
            dec[0] = pin_rise[0] & COUNT_IN_B_I;
         end else begin
            inc[0] = (pin_rise[0] & ~COUNT_IN_B_I) | (pin_fall[0] & COUNT_IN_B_I) |
                     (pin_rise[1] & COUNT_IN_A_I) | (pin_fall[1] & ~COUNT_IN_A_I);
            dec[0] = (pin_rise[0] & COUNT_IN_B_I) | (pin_fall[0] & ~COUNT_IN_B_I) |
                     (pin_rise[1] & ~COUNT_IN_A_I) | (pin_fall[1] & COUNT_IN_A_I);
         end
      end
      if (two_ph2) begin
         if (dir_md) begin
            inc[2] = pin_rise[3] & ~COUNT_IN_D_I;
            dec[2] = pin_rise[3] & COUNT_IN_D_I;
         end else begin
            inc[2] = (pin_rise[3] & ~COUNT_IN_D_I) | (pin_fall[3] & COUNT_IN_D_I) |
                     (pin_rise[4] & COUNT_IN_C_I) | (pin_fall[4] & ~COUNT_IN_C_I);
            dec[2] = (pin_rise[3] & COUNT_IN_D_I) | (pin_fall[3] & ~COUNT_IN_D_I) |
                     (pin_rise[4] & ~COUNT_IN_C_I) | (pin_fall[4] & COUNT_IN_C_I);
         end
      end
      inc = inc & en;
      dec = dec & en;
   end

   // Each shared clear input reaches exactly one channel [RULE12]
   // A two-phase channel always owns its clear, since its partner is not counting [RULE9]
   assign clr[0] = pin_rise[2] & (~st_reg.ctrl[`HSC_CTRL_CLR0_POS] | two_ph0);
   assign clr[1] = pin_rise[2] & st_reg.ctrl[`HSC_CTRL_CLR0_POS] & ~two_ph0;
   assign clr[2] = pin_rise[5] & (~st_reg.ctrl[`HSC_CTRL_CLR2_POS] | two_ph2);
   assign clr[3] = pin_rise[5] & st_reg.ctrl[`HSC_CTRL_CLR2_POS] & ~two_ph2;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [2:0] osel;
      logic       irq_wr;
      osel    = 3'h0;
      irq_wr  = wr & reg_hit(PADDR_I, `HSC_IRQ_STAT_OFS);
      st_next = st_reg;
      hit     = 4'h0;

      for (int c = 0; c < 4; c++) begin // [RULE1]
         if (clr[c]) begin
            st_next.count[c] = `HSC_COUNT_RESET; // [RULE14]
         end else if (inc[c] ^ dec[c]) begin
            st_next.count[c] = step(st_reg.count[c], dec[c]);
         end
         if (wr && reg_hit(PADDR_I, 12'(`HSC_CH0_ELAPSED_OFS + 8 * c))) begin // [RULE10]
            st_next.count[c] = PWDATA_I;
         end
         if (wr && reg_hit(PADDR_I, 12'(`HSC_CH0_TARGET_OFS + 8 * c))) begin // [RULE10]
            st_next.target[c] = PWDATA_I;
         end
         // Compare the new value, so a count that steps onto the target matches once
         hit[c] = st_reg.ctrl[`HSC_CTRL_MATCH_POS + c] &&
                  (st_next.count[c] != st_reg.count[c]) &&
                  (st_next.count[c] == st_reg.target[c]);
         case (st_reg.st[c])
            HSC_IDLE: begin
               // Busy trails the enables by one cycle
               st_next.busy[c] = en[c] | st_reg.ctrl[`HSC_CTRL_MATCH_POS + c]; // [RULE15]
               if (st_next.busy[c]) begin
                  st_next.st[c] = HSC_RUN;
               end
            end
            HSC_RUN: begin
               if (hit[c]) begin
                  st_next.st[c] = HSC_MATCH;
               end else if (!(en[c] | st_reg.ctrl[`HSC_CTRL_MATCH_POS + c])) begin
                  st_next.st[c]   = HSC_IDLE;
                  st_next.busy[c] = 1'b0; // [RULE15]
               end
            end
            HSC_MATCH: begin
               // One-shot match: the match enable is dropped after firing
               st_next.st[c] = HSC_RUN;
            end
            default: begin
               st_next.st[c] = HSC_IDLE;
            end
         endcase
         if (irq_wr && PWDATA_I[c]) begin
            st_next.irq_stat[c] = 1'b0;
         end
         // After the clear, so an event in the same cycle as a clear is kept
         if (hit[c]) begin
            osel = st_reg.outsel[4 * c +: 3]; // [RULE13]
            st_next.outs[osel] = st_reg.ctrl[`HSC_CTRL_MVAL_POS + c]; // [RULE6]
            st_next.ctrl[`HSC_CTRL_MATCH_POS + c] = 1'b0;
            st_next.irq_stat[c] = 1'b1;
         end
      end

      // Writes come last so software wins over a match; masks keep spare bits zero
      if (wr && reg_hit(PADDR_I, `HSC_CTRL_OFS)) begin
         st_next.ctrl = PWDATA_I & 32'h000f_ffff;
      end
      if (wr && reg_hit(PADDR_I, `HSC_OUTSEL_OFS)) begin
         st_next.outsel = PWDATA_I & 32'h0000_7777;
      end
      if (wr && reg_hit(PADDR_I, `HSC_IRQ_MASK_OFS)) begin
         st_next.irq_mask = PWDATA_I[3:0];
      end
      if (wr && reg_hit(PADDR_I, `HSC_OUT_STATE_OFS)) begin
         st_next.outs = PWDATA_I[7:0];
      end

      // Read data captured in setup so the access phase needs no wait
      // A count moving between setup and access reads as its setup-time value
      if (rd) begin
         st_next.rdata = 32'h0000_0000;
         for (int c = 0; c < 4; c++) begin
            if (reg_hit(PADDR_I, 12'(`HSC_CH0_ELAPSED_OFS + 8 * c))) begin
               st_next.rdata = st_reg.count[c];
            end
            if (reg_hit(PADDR_I, 12'(`HSC_CH0_TARGET_OFS + 8 * c))) begin
               st_next.rdata = st_reg.target[c];
            end
         end
         if (reg_hit(PADDR_I, `HSC_CTRL_OFS)) begin
            st_next.rdata = st_reg.ctrl;
         end
         if (reg_hit(PADDR_I, `HSC_OUTSEL_OFS)) begin
            st_next.rdata = st_reg.outsel;
         end
         if (reg_hit(PADDR_I, `HSC_FLAG_OFS)) begin
            st_next.rdata = {28'h0000000, st_reg.busy};
         end
         if (reg_hit(PADDR_I, `HSC_IRQ_STAT_OFS)) begin
            st_next.rdata = {28'h0000000, st_reg.irq_stat};
         end
         if (reg_hit(PADDR_I, `HSC_IRQ_MASK_OFS)) begin
            st_next.rdata = {28'h0000000, st_reg.irq_mask};
         end
         if (reg_hit(PADDR_I, `HSC_OUT_STATE_OFS)) begin
            st_next.rdata = {24'h000000, st_reg.outs};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_reg.count    <= '0;
         st_reg.target   <= '0;
         st_reg.ctrl     <= `HSC_CTRL_RESET;
         st_reg.outsel   <= `HSC_OUTSEL_RESET;
         st_reg.irq_stat <= 4'h0;
         st_reg.irq_mask <= 4'h0;
         st_reg.outs     <= 8'h00;
         st_reg.busy     <= 4'h0;
         st_reg.rdata    <= 32'h0000_0000;
         // An assignment pattern keeps the enum type of every channel state
         st_reg.st       <= '{default: HSC_IDLE};
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign PRDATA_O      = st_reg.rdata;
   // No wait states: every register answers in its first access cycle
   assign PREADY_O      = 1'b1;
   // Unmapped or unaligned accesses end with an error and change nothing
   assign PSLVERR_O     = PSEL_I & PENABLE_I & ~mapped;
   assign OUT_CONTACT_O = st_reg.outs;
   assign CHAN_FLAG_O   = st_reg.busy;
   assign IRQ_O         = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule : hsc_top

// ===== bench/hsc_assertions.sv
`timescale 1ns/10ps
module hsc_assertions
   import hsc_pkg::*;
#(
   parameter int NUM_CH  = 4,
   parameter int NUM_OUT = 8
)(
   input wire logic        SYS_CLK_I,
   input wire logic        RST_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        COUNT_IN_A_I,
   input wire logic        COUNT_IN_B_I,
   input wire logic        CLEAR_IN_LOW_I,
   input wire logic        COUNT_IN_C_I,
   input wire logic        COUNT_IN_D_I,
   input wire logic        CLEAR_IN_HIGH_I,
   input wire logic [7:0]  OUT_CONTACT_O,
   input wire logic [3:0]  CHAN_FLAG_O,
   input wire logic        IRQ_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);
   //////////
   // Outputs may move only a few cycles after a write or a high field line
   logic [3:0] hist;
   wire        wr  = PSEL_I && PENABLE_I && PWRITE_I;
   wire        cw  = wr && PADDR_I == 12'h020;
   wire        act = wr || COUNT_IN_A_I || COUNT_IN_B_I || CLEAR_IN_LOW_I
                     || COUNT_IN_C_I || COUNT_IN_D_I || CLEAR_IN_HIGH_I;
   always_ff @(posedge SYS_CLK_I or posedge RST_I)
      if (RST_I) hist <= 4'hf;
      else hist <= {hist[2:0], act};
   //////////
   sequence s_acc;
      PSEL_I ##1 PSEL_I && PENABLE_I;
   endsequence
   property p_err;
      (s_acc ##0 (PADDR_I > 12'h034 || PADDR_I[1:0] != 2'h0)) |-> PSLVERR_O;
   endproperty
   property p_ok;
      (s_acc ##0 (PADDR_I <= 12'h034 && PADDR_I[1:0] == 2'h0)) |-> !PSLVERR_O;
   endproperty
   property p_rdy;
      PSEL_I |-> PREADY_O;
   endproperty
   property p_prd;
      !(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O);
   endproperty
   property p_out;
      $changed(OUT_CONTACT_O) |-> |hist;
   endproperty
   property p_irq;
      $rose(IRQ_O) |-> |hist;
   endproperty
   property p_flr;
      $rose(|CHAN_FLAG_O) |-> $past(cw) || $past(cw, 2);
   endproperty
   property p_flf;
      $fell(|CHAN_FLAG_O) |-> |hist;
   endproperty
   a_err: assert property (p_err) else $error("no error on bad address");
   a_ok: assert property (p_ok) else $error("error on mapped address");
   a_rdy: assert property (p_rdy) else $error("ready low");
   a_prd: assert property (p_prd) else $error("read data moved");
   a_out: assert property (p_out) else $error("contact moved uncaused");
   a_irq: assert property (p_irq) else $error("irq rose uncaused");
   a_flr: assert property (p_flr) else $error("flag rose uncaused");
   a_flf: assert property (p_flf) else $error("flag fell uncaused");
endmodule : hsc_assertions

// ===== bench/hsc_sensor.sv
`timescale 1ns/10ps
// Field pulse source; pulsed lines fall back to their base_i level after each pulse
module hsc_sensor (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic [5:0] req_i,
   input  wire logic [5:0] base_i,
   output logic      [5:0] line_o,
   output logic            busy_o
);
   logic [5:0] act = '0;
   int         n   = 0;
   int         w   = 1;
   always @(posedge clk_i) begin
      if (n == 0 && req_i != 6'h0) begin
         act <= req_i;
         w   <= slow_i ? 3 : 1;
         n   <= slow_i ? 6 : 2;
      end else if (n > 0) begin
         n <= n - 1;
         if (n == w + 1) act <= 6'h0;
      end
   end
   assign line_o = base_i | act;
   assign busy_o = n != 0;
endmodule : hsc_sensor

// ===== bench/four_channel_high_speed_counter_bench.sv
`timescale 1ns/10ps
module four_channel_high_speed_counter_bench;
   import hsc_pkg::*;
   logic        clk = 0, rst = 1, ps = 0, pe = 0, pw = 0, slow = 0;
   logic        sb, perr, prdy, irq, er;
   logic [11:0] pa = '0;
   logic [31:0] pd = '0, prd, rd, ctl;
   logic [5:0]  rq = '0, bs = '0, ln;
   logic [7:0]  oc;
   logic [3:0]  fl;
   hsc_count_t  v[8];
   int          m[4];
   logic [5:0]  qd[4] = '{6'h0a, 6'h1b, 6'h11, 6'h00};
   int          fails = 0, cmp_count = 0;
   hsc_top hsc_top_i (
      .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(ps), .PENABLE_I(pe), .PWRITE_I(pw),
      .PADDR_I(pa), .PWDATA_I(pd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
      .COUNT_IN_A_I(ln[0]), .COUNT_IN_B_I(ln[1]), .CLEAR_IN_LOW_I(ln[2]),
      .COUNT_IN_C_I(ln[3]), .COUNT_IN_D_I(ln[4]), .CLEAR_IN_HIGH_I(ln[5]),
      .OUT_CONTACT_O(oc), .CHAN_FLAG_O(fl), .IRQ_O(irq));
   hsc_sensor hsc_sensor_i (.clk_i(clk), .slow_i(slow), .req_i(rq), .base_i(bs),
      .line_o(ln), .busy_o(sb));
   //////////
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      ps <= 1; pe <= 0; pw <= w; pa <= a; pd <= d;
      @(posedge clk);
      pe <= 1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      ps <= 0;
      pe <= 0;
   endtask : apb
   task automatic rg(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk($sformatf("reg %h", a), rd, e);
   endtask : rg
   task automatic cnt(input logic [5:0] p);
      slow <= 1'($urandom);
      rq <= p;
      @(posedge clk);
      rq <= 0;
      do @(posedge clk); while (sb === 1'b1);
      repeat (3) @(posedge clk);
      // Clear is applied last since it beats a count in the same cycle
      if (p[0]) m[0] += (ctl[8] ? bs[1] : ctl[4]) ? -1 : 1;
      if (p[1] && !ctl[8]) m[1] += ctl[5] ? -1 : 1;
      if (p[3]) m[2] += ctl[6] ? -1 : 1;
      if (p[4] && !ctl[9]) m[3] += ctl[7] ? -1 : 1;
      if (p[2]) m[ctl[8] ? 0 : ctl[10]] = 0;
      if (p[5]) m[ctl[9] ? 2 : 2 + ctl[11]] = 0;
   endtask : cnt
   task automatic test_done();
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   //////////
   initial begin
      forever #2 clk = ~clk;
   end
   initial begin
      #200000;
      fails++;
      test_done();
   end
   initial begin
      void'($urandom(32'h36c97899));
      repeat (2) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 8; i++) rg(12'(4 * i), 32'h0);
      for (int i = 0; i < 8; i++) begin
         v[i] = 32'($signed(24'($urandom)));
         apb(1, 12'(4 * i), v[i]);
      end
      for (int i = 0; i < 8; i++) rg(12'(4 * i), v[i]);
      for (int i = 0; i < 4; i++) m[i] = v[2 * i];
      apb(0, 12'h040, 0);
      chk("slverr", er, 1);
      chk("unmapped", rd, 0);
      ctl = 32'h0000_002f;
      apb(1, 12'h020, ctl);
      repeat (2) @(posedge clk);
      chk("flags", fl, 4'hf);
      apb(1, 12'h000, 32'h7fff_ffff);
      apb(1, 12'h008, 32'h8000_0000);
      m[0] = 32'h7fff_ffff;
      m[1] = 32'h8000_0000;
      cnt(6'h03);
      rg(12'h000, 32'h8000_0000);
      rg(12'h008, 32'h7fff_ffff);
      repeat (12) cnt(6'($urandom) & 6'h1b);
      for (int c = 0; c < 4; c++) rg(12'(8 * c), m[c]);
      cnt(6'h24);
      ctl = 32'h0000_0c2f;
      apb(1, 12'h020, ctl);
      cnt(6'h3f);
      for (int c = 0; c < 4; c++) rg(12'(8 * c), m[c]);
      // Channel 2 turns contact 5 on, channel 3 turns contact 7 off
      apb(1, 12'h034, 32'h80);
      apb(1, 12'h024, 32'h7500);
      apb(1, 12'h030, 32'h0);
      apb(1, 12'h014, 32'(m[2] + 2));
      apb(1, 12'h01c, 32'(m[3] + 1));
      ctl = 32'h0004_cc2f;
      apb(1, 12'h020, ctl);
      cnt(6'h18);
      cnt(6'h08);
      chk("contacts", oc, 8'h20);
      chk("masked", irq, 0);
      rg(12'h02c, 32'hc);
      apb(1, 12'h030, 32'h4);
      @(posedge clk);
      chk("irq", irq, 1);
      apb(1, 12'h02c, 32'h4);
      @(posedge clk);
      chk("irq clr", irq, 0);
      rg(12'h02c, 32'h8);
      ctl = 32'h0000_0d2f;
      apb(1, 12'h020, ctl);
      cnt(6'h01);
      bs <= 6'h02;
      cnt(6'h01);
      bs <= 6'h00;
      rg(12'h000, m[0]);
      rg(12'h008, m[1]);
      // A two-phase channel keeps its clear input whatever bit 10 says
      cnt(6'h24);
      for (int c = 0; c < 4; c++) rg(12'(8 * c), m[c]);
      // Quadrature on both pairs: channel 0 backwards, channel 2 forwards
      ctl = 32'h0000_030f;
      apb(1, 12'h020, ctl);
      foreach (qd[i]) begin
         bs <= qd[i];
         repeat (2) @(posedge clk);
      end
      m[0] -= 4;
      m[2] += 4;
      rg(12'h000, m[0]);
      rg(12'h010, m[2]);
      apb(1, 12'h020, 32'h0);
      repeat (2) @(posedge clk);
      chk("idle", fl, 4'h0);
      test_done();
   end
endmodule : four_channel_high_speed_counter_bench
bind hsc_top hsc_assertions #(.NUM_CH(NUM_CH), .NUM_OUT(NUM_OUT)) hsc_assertions_i (
   .SYS_CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
   .PRDATA_O, .PREADY_O, .PSLVERR_O, .COUNT_IN_A_I, .COUNT_IN_B_I, .CLEAR_IN_LOW_I,
   .COUNT_IN_C_I, .COUNT_IN_D_I, .CLEAR_IN_HIGH_I, .OUT_CONTACT_O, .CHAN_FLAG_O, .IRQ_O);
